// *** inc/srx_pkg.sv ***
// constants, types and helpers shared by the instruction execution slice
package srx_pkg;

  // wishbone address and data layout
  localparam int unsigned ADR_W       = 12;
  localparam int unsigned DAT_W       = 32;
  localparam int unsigned SEL_W       = 4;

  // register offsets (byte addresses)
  localparam logic [11:0] ADR_CMD     = 12'h000;
  localparam logic [11:0] ADR_ACC     = 12'h004;
  localparam logic [11:0] ADR_STAT    = 12'h008;
  localparam logic [11:0] ADR_PC      = 12'h00c;
  localparam logic [11:0] ADR_PUSH    = 12'h010;
  localparam logic [11:0] ADR_WDOG    = 12'h014;
  localparam logic [11:0] ADR_WAKE    = 12'h018;

  // file register page: adr[11:9] selects it, adr[8:2] is the index
  localparam int unsigned FILE_LSB    = 9;
  localparam logic [2:0]  FILE_PAGE   = 3'h1;
  localparam int unsigned FILE_AW     = 7;
  localparam int unsigned WORD_LSB    = 2;

  // command word fields
  localparam int unsigned OP_LSB      = 0;
  localparam int unsigned OP_W        = 3;
  localparam int unsigned DEST_BIT    = 3;
  localparam int unsigned FADR_LSB    = 4;
  localparam int unsigned LIT_LSB     = 16;

  // command readback bits
  localparam int unsigned CMD_BUSY    = 0;
  localparam int unsigned CMD_HALT    = 1;

  // status bit positions and field width
  localparam int unsigned ST_C        = 0;
  localparam int unsigned ST_DC       = 1;
  localparam int unsigned ST_Z        = 2;
  localparam int unsigned ST_PD_N     = 3;
  localparam int unsigned ST_TO_N     = 4;
  localparam int unsigned ST_W        = 5;

  // reset and fixed values
  localparam logic        FLAG_N_RST  = 1'b1;
  localparam logic        DEST_ACC    = 1'b0;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;

  // operations carried by the command word
  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_HALT  = 3'h1,
    OP_RET   = 3'h2,
    OP_RRF   = 3'h3,
    OP_LITERAL_MINUS_ACC_OP = 3'h4,
    OP_REG_MINUS_ACC_OP = 3'h5
  } srx_op_t;

  // sequencer states, gray along run -> return -> run and run -> halt
  typedef enum logic [1:0] {
    S_RUN  = 2'b00,
    S_RET2 = 2'b01,
    S_HALT = 2'b10
  } srx_state_t;

  // one wishbone request as the master drives it
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] dat;
  } srx_wb_req_t;

  // subtract result with its flags
  typedef struct packed {
    logic       c;
    logic       dc;
    logic [7:0] res;
  } srx_alu_t;

  // a minus b, carry and digit carry mean no borrow
  function automatic srx_alu_t srx_sub(input logic [7:0] a,
                                       input logic [7:0] b);
    srx_alu_t r;
    r.res = a - b;
    r.c   = (a >= b);
    r.dc  = (a[3:0] >= b[3:0]);
    return r;
  endfunction

endpackage

// *** hdl/srx_exec.sv ***
// execution unit for halt, return, rotate right and both subtracts
//
// How it works
// - the halt operation clears the watchdog counter and its prescaler.
// - halt writes 0 to the power-down flag and 1 to the time-out flag.
// - after a halt the core executes nothing and its counters stand until a write to the wake register.
// - return pops the stack into the program counter and keeps all flags.
// - return takes two cycles, the second one refuses new commands.
// - rotate right moves old carry into bit 7, old bit 0 into carry only.
// - rotate right result goes to the accumulator for dest 0, file for 1.
// - literal minus accumulator goes to the accumulator; sets c, dc, z.
// - file minus accumulator sets c, dc and z.
// - file minus accumulator lands in acc for dest 0, in the file for 1.
`timescale 1ns/1ns
module srx_exec #(
  parameter int unsigned PC_W        = 13,
  parameter int unsigned STACK_DEPTH = 8,
  parameter int unsigned WDOG_W      = 8,
  parameter int unsigned PRE_W       = 8
) (
  // clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      reset_i,
  // wishbone slave
  input  wire srx_pkg::srx_wb_req_t      wb_req_i,
  output logic                           wb_ack_o,
  output logic [srx_pkg::DAT_W-1:0]      wb_dat_o,
  // core state
  output logic                           sleep_o,
  output logic [PC_W-1:0]                pc_o
);

  localparam int unsigned SP_W  = $clog2(STACK_DEPTH);
  localparam int unsigned FILES = 1 << srx_pkg::FILE_AW;

  // refuse sizes the logic cannot serve
  if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH ||
      PC_W < 1 || PC_W > srx_pkg::DAT_W ||
      WDOG_W + PRE_W > srx_pkg::DAT_W) begin : g_bad_param
    $error("srx_exec: unsupported parameter values");
  end

  // state
  srx_pkg::srx_state_t    state_r;
  logic                   sleep_r;
  logic                   wb_ack_r;
  logic [srx_pkg::DAT_W-1:0] wb_dat_r;
  logic [7:0]             acc_r;
  logic                   c_r;
  logic                   dc_r;
  logic                   z_r;
  logic                   pd_n_r;
  logic                   to_n_r;
  logic [PC_W-1:0]        pc_r;
  logic [SP_W-1:0]        sp_r;
  logic [WDOG_W-1:0]      wdog_r;
  logic [PRE_W-1:0]       pre_r;
  logic [7:0]             file_mem [FILES];
  logic [PC_W-1:0]        stack_mem [STACK_DEPTH];

  // next values
  logic [7:0]             acc_nxt;
  logic                   c_nxt;
  logic                   dc_nxt;
  logic                   z_nxt;
  logic                   file_we_nxt;
  logic [7:0]             file_wd_nxt;
  logic [srx_pkg::FILE_AW-1:0] file_wa_nxt;
  srx_pkg::srx_state_t    state_nxt;

  // bus decode
  wire logic       req_w     = wb_req_i.cyc & wb_req_i.stb;
  wire logic       ack_nxt   = req_w & ~wb_ack_r;
  wire logic       wr_w      = req_w & wb_req_i.we & wb_ack_r;
  wire logic       lane0_w   = wb_req_i.sel[0];
  wire logic       hit_cmd_w  = (wb_req_i.adr == srx_pkg::ADR_CMD);
  wire logic       hit_acc_w  = (wb_req_i.adr == srx_pkg::ADR_ACC);
  wire logic       hit_stat_w = (wb_req_i.adr == srx_pkg::ADR_STAT);
  wire logic       hit_pc_w   = (wb_req_i.adr == srx_pkg::ADR_PC);
  wire logic       hit_push_w = (wb_req_i.adr == srx_pkg::ADR_PUSH);
  wire logic       hit_wdog_w = (wb_req_i.adr == srx_pkg::ADR_WDOG);
  wire logic       hit_wake_w = (wb_req_i.adr == srx_pkg::ADR_WAKE);
  wire logic       hit_file_w =
    (wb_req_i.adr[srx_pkg::ADR_W-1:srx_pkg::FILE_LSB] == srx_pkg::FILE_PAGE);
  wire logic [srx_pkg::FILE_AW-1:0] bus_fadr_w =
    wb_req_i.adr[srx_pkg::FILE_LSB-1:srx_pkg::WORD_LSB];

  // command word fields
  wire srx_pkg::srx_op_t op_w =
    srx_pkg::srx_op_t'(wb_req_i.dat[srx_pkg::OP_LSB +: srx_pkg::OP_W]);
  wire logic       dest_w = wb_req_i.dat[srx_pkg::DEST_BIT];
  wire logic [srx_pkg::FILE_AW-1:0] fadr_w =
    wb_req_i.dat[srx_pkg::FADR_LSB +: srx_pkg::FILE_AW];
  wire logic [7:0] lit_w = wb_req_i.dat[srx_pkg::LIT_LSB +: 8];

  // a command is taken only while running, not in halt or return tail
  wire logic issue_w = wr_w & hit_cmd_w & lane0_w &
                       (state_r == srx_pkg::S_RUN);
  wire logic exec_halt_w  = issue_w & (op_w == srx_pkg::OP_HALT);
  wire logic exec_ret_w   = issue_w & (op_w == srx_pkg::OP_RET);
  wire logic exec_rrf_w   = issue_w & (op_w == srx_pkg::OP_RRF);
  wire logic exec_literal_minus_acc_op_w = issue_w & (op_w == srx_pkg::OP_LITERAL_MINUS_ACC_OP);
  wire logic exec_reg_minus_acc_op_w = issue_w & (op_w == srx_pkg::OP_REG_MINUS_ACC_OP);
  wire logic exec_any_w   = exec_halt_w | exec_ret_w | exec_rrf_w |
                            exec_literal_minus_acc_op_w | exec_reg_minus_acc_op_w;

  // operands and results
  wire logic [7:0]      fval_w = file_mem[fadr_w];
  wire logic [7:0]      rrf_res_w = {c_r, fval_w[7:1]};
  wire srx_pkg::srx_alu_t sub_l_w = srx_pkg::srx_sub(lit_w, acc_r);
  wire srx_pkg::srx_alu_t sub_f_w = srx_pkg::srx_sub(fval_w, acc_r);
  wire logic [SP_W-1:0] sp_dec_w = sp_r - 1'b1;
  wire logic [PC_W-1:0] stack_top_w = stack_mem[sp_dec_w];
  wire logic            pre_wrap_w = &pre_r;

  // status assembly for readback
  logic [srx_pkg::ST_W-1:0] stat_w;
  always_comb begin
    stat_w                  = '0;
    stat_w[srx_pkg::ST_C]   = c_r;
    stat_w[srx_pkg::ST_DC]  = dc_r;
    stat_w[srx_pkg::ST_Z]   = z_r;
    stat_w[srx_pkg::ST_PD_N] = pd_n_r;
    stat_w[srx_pkg::ST_TO_N] = to_n_r;
  end

  // read data select, unmapped addresses read as zero
  logic [srx_pkg::DAT_W-1:0] cmd_rd_w;
  always_comb begin
    cmd_rd_w                    = '0;
    cmd_rd_w[srx_pkg::CMD_BUSY] = (state_r == srx_pkg::S_RET2);
    cmd_rd_w[srx_pkg::CMD_HALT] = (state_r == srx_pkg::S_HALT);
  end
  wire logic [srx_pkg::DAT_W-1:0] rd_w =
    hit_cmd_w  ? cmd_rd_w :
    hit_acc_w  ? srx_pkg::DAT_W'(acc_r) :
    hit_stat_w ? srx_pkg::DAT_W'(stat_w) :
    hit_pc_w   ? srx_pkg::DAT_W'(pc_r) :
    hit_push_w ? srx_pkg::DAT_W'(sp_r) :
    hit_wdog_w ? srx_pkg::DAT_W'({pre_r, wdog_r}) :
    hit_file_w ? srx_pkg::DAT_W'(file_mem[bus_fadr_w]) :
    '0;

  // datapath next values for accumulator, flags and file write
  always_comb begin
    acc_nxt     = acc_r;
    c_nxt       = c_r;
    dc_nxt      = dc_r;
    z_nxt       = z_r;
    file_we_nxt = 1'b0;
    file_wd_nxt = wb_req_i.dat[7:0];
    file_wa_nxt = bus_fadr_w;
    if (exec_rrf_w) begin
      c_nxt = fval_w[0];
      if (dest_w == srx_pkg::DEST_ACC) begin
        acc_nxt = rrf_res_w;
      end else begin
        file_we_nxt = 1'b1;
        file_wd_nxt = rrf_res_w;
        file_wa_nxt = fadr_w;
      end
    end else if (exec_literal_minus_acc_op_w) begin
      acc_nxt = sub_l_w.res;
      c_nxt   = sub_l_w.c;
      dc_nxt  = sub_l_w.dc;
      z_nxt   = (sub_l_w.res == srx_pkg::BYTE_ZERO);
    end else if (exec_reg_minus_acc_op_w) begin
      c_nxt  = sub_f_w.c;
      dc_nxt = sub_f_w.dc;
      z_nxt  = (sub_f_w.res == srx_pkg::BYTE_ZERO);
      if (dest_w == srx_pkg::DEST_ACC) begin
        acc_nxt = sub_f_w.res;
      end else begin
        file_we_nxt = 1'b1;
        file_wd_nxt = sub_f_w.res;
        file_wa_nxt = fadr_w;
      end
    end else if (wr_w & lane0_w & hit_acc_w) begin
      acc_nxt = wb_req_i.dat[7:0];
    end else if (wr_w & lane0_w & hit_stat_w) begin
      c_nxt  = wb_req_i.dat[srx_pkg::ST_C];
      dc_nxt = wb_req_i.dat[srx_pkg::ST_DC];
      z_nxt  = wb_req_i.dat[srx_pkg::ST_Z];
    end else if (wr_w & lane0_w & hit_file_w) begin
      file_we_nxt = 1'b1;
    end
  end

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      srx_pkg::S_RUN: begin
        if (exec_ret_w) begin
          state_nxt = srx_pkg::S_RET2;
        end else if (exec_halt_w) begin
          state_nxt = srx_pkg::S_HALT;
        end
      end
      srx_pkg::S_RET2: begin
        state_nxt = srx_pkg::S_RUN;
      end
      srx_pkg::S_HALT: begin
        if (wr_w & lane0_w & hit_wake_w) begin
          state_nxt = srx_pkg::S_RUN;
        end
      end
      // the unused code falls back to running
      default: begin
        state_nxt = srx_pkg::S_RUN;
      end
    endcase
  end

  // bus answer: ack one cycle after the request, for one cycle
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= '0;
    end else begin
      wb_ack_r <= ack_nxt;
      wb_dat_r <= ack_nxt ? rd_w : '0;
    end
  end

  // sequencer, accumulator and flags
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_r <= srx_pkg::S_RUN;
      sleep_r <= 1'b0;
      acc_r   <= srx_pkg::BYTE_ZERO;
      c_r     <= 1'b0;
      dc_r    <= 1'b0;
      z_r     <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sleep_r <= (state_nxt == srx_pkg::S_HALT);
      acc_r   <= acc_nxt;
      c_r     <= c_nxt;
      dc_r    <= dc_nxt;
      z_r     <= z_nxt;
    end
  end

  // power-down and time-out flags
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pd_n_r <= srx_pkg::FLAG_N_RST;
      to_n_r <= srx_pkg::FLAG_N_RST;
    end else if (exec_halt_w) begin
      pd_n_r <= 1'b0;
      to_n_r <= 1'b1;
    end
  end

  // watchdog counter and prescaler, frozen while halted
  always_ff @(posedge clock_i) begin
    if (reset_i || exec_halt_w) begin
      wdog_r <= '0;
      pre_r  <= '0;
    end else if (state_r != srx_pkg::S_HALT) begin
      pre_r  <= pre_r + 1'b1;
      wdog_r <= pre_wrap_w ? wdog_r + 1'b1 : wdog_r;
    end
  end

  // program counter and return stack pointer
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pc_r <= '0;
      sp_r <= '0;
    end else if (exec_ret_w) begin
      pc_r <= stack_top_w;
      sp_r <= sp_dec_w;
    end else if (wr_w & hit_pc_w) begin
      pc_r <= wb_req_i.dat[PC_W-1:0];
    end else if (wr_w & hit_push_w) begin
      sp_r <= sp_r + 1'b1;
    end
  end

  // return stack storage, circular like the hardware stack
  always_ff @(posedge clock_i) begin
    if (wr_w & hit_push_w) begin
      stack_mem[sp_r] <= wb_req_i.dat[PC_W-1:0];
    end
  end

  // file register storage
  always_ff @(posedge clock_i) begin
    if (file_we_nxt) begin
      file_mem[file_wa_nxt] <= file_wd_nxt;
    end
  end

  // outputs straight from flops
  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;
  assign sleep_o  = sleep_r;
  assign pc_o     = pc_r;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence s_ret_tail;
    (state_r == srx_pkg::S_RET2) ##1 (state_r == srx_pkg::S_RUN);
  endsequence

  sequence s_asleep;
    (state_r == srx_pkg::S_HALT) && (pd_n_r == 1'b0);
  endsequence

  property p_halt_wdog;
    exec_halt_w |=> (wdog_r == '0) && (pre_r == '0) [*2];
  endproperty
  a_halt_wdog: assert property (p_halt_wdog)
    else $error("watchdog not cleared by halt");

  property p_halt_flags;
    exec_halt_w |=> s_asleep and (to_n_r == 1'b1);
  endproperty
  a_halt_flags: assert property (p_halt_flags)
    else $error("halt flags wrong");

  property p_halt_blocks;
    (state_r == srx_pkg::S_HALT) |-> !exec_any_w && $stable(pc_r) ##1
      $stable(wdog_r) && $stable(pre_r);
  endproperty
  a_halt_blocks: assert property (p_halt_blocks)
    else $error("execution while halted");

  property p_ret_pc;
    exec_ret_w |=> (pc_r == $past(stack_top_w)) &&
                   $stable(c_r) && $stable(z_r) && $stable(dc_r);
  endproperty
  a_ret_pc: assert property (p_ret_pc)
    else $error("return loaded wrong pc or changed flags");

  property p_ret_two;
    exec_ret_w |=> s_ret_tail;
  endproperty
  a_ret_two: assert property (p_ret_two)
    else $error("return not two cycles");

  property p_rrf;
    exec_rrf_w |=> (c_r == $past(fval_w[0])) && $stable(z_r);
  endproperty
  a_rrf: assert property (p_rrf)
    else $error("rotate carry wrong");

  property p_rrf_acc;
    exec_rrf_w && (dest_w == srx_pkg::DEST_ACC) |=>
      acc_r == $past(rrf_res_w);
  endproperty
  a_rrf_acc: assert property (p_rrf_acc)
    else $error("rotate result not in accumulator");

  property p_literal_minus_acc_op;
    exec_literal_minus_acc_op_w |=> (acc_r == $past(sub_l_w.res)) &&
                     (z_r == (acc_r == srx_pkg::BYTE_ZERO));
  endproperty
  a_literal_minus_acc_op: assert property (p_literal_minus_acc_op)
    else $error("literal subtract wrong");

  property p_reg_minus_acc_op_flags;
    exec_reg_minus_acc_op_w |=> (c_r == $past(sub_f_w.c)) &&
                     (dc_r == $past(sub_f_w.dc));
  endproperty
  a_reg_minus_acc_op_flags: assert property (p_reg_minus_acc_op_flags)
    else $error("file subtract flags wrong");

  property p_reg_minus_acc_op_file;
    exec_reg_minus_acc_op_w && (dest_w != srx_pkg::DEST_ACC) |=> $stable(acc_r);
  endproperty
  a_reg_minus_acc_op_file: assert property (p_reg_minus_acc_op_file)
    else $error("file subtract touched accumulator");

  property p_borrow;
    exec_literal_minus_acc_op_w |=> c_r == ($past(lit_w) >= $past(acc_r));
  endproperty
  a_borrow: assert property (p_borrow)
    else $error("carry does not mean no borrow");

endmodule // srx_exec

// *** tb/srx_exec_tb.sv ***
// self-checking testbench for the halt, return, rotate and subtract unit
`timescale 1ns/1ns
module srx_exec_tb;

  // design connections
  logic                  clock_i;
  logic                  reset_i;
  srx_pkg::srx_wb_req_t  wb_req_i;
  logic                  wb_ack_o;
  logic [31:0]           wb_dat_o;
  logic                  sleep_o;
  logic [12:0]           pc_o;

  // bench state
  int                    n_mismatch;
  int                    num_checks;
  logic [31:0]           rd;
  logic [7:0]            res;
  logic [2:0]            ef;
  logic [7:0]            ka [6];
  logic [7:0]            wa [6];
  logic [7:0]            rv [4];
  logic                  rc [4];

  srx_exec dut (
    .clock_i  (clock_i),
    .reset_i  (reset_i),
    .wb_req_i (wb_req_i),
    .wb_ack_o (wb_ack_o),
    .wb_dat_o (wb_dat_o),
    .sleep_o  (sleep_o),
    .pc_o     (pc_o)
  );

  // 250 MHz clock
  initial clock_i = 1'b0;
  always #2 clock_i = ~clock_i;

  // compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb_op(input logic w, input logic [11:0] a,
                       input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
    do begin
      @(posedge clock_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t no bus acknowledge", $time);
    end
    wb_req_i <= '0;
    @(posedge clock_i);
  endtask

  // shorthand writes and reads with all byte lanes
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb_op(1'b1, a, 4'hf, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    wb_op(1'b0, a, 4'hf, 32'h0000_0000);
    check(rd, exp);
  endtask

  // command word and file register address builders
  function automatic logic [31:0] cw(input logic [2:0] op, input logic d,
                                     input logic [6:0] f,
                                     input logic [7:0] k);
    return {8'h00, k, 5'h00, f, d, op};
  endfunction
  function automatic logic [11:0] fa(input logic [6:0] f);
    return {srx_pkg::FILE_PAGE, f, 2'b00};
  endfunction

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #80000;
    n_mismatch++;
    summarize();
  end

  // main test sequence
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    reset_i    = 1'b1;
    wb_req_i   = '0;
    ka = '{8'h05, 8'h03, 8'h10, 8'h42, 8'hff, 8'h00};
    wa = '{8'h03, 8'h05, 8'h01, 8'h42, 8'h00, 8'h01};
    rv = '{8'h81, 8'h80, 8'h01, 8'h00};
    rc = '{1'b1, 1'b0, 1'b0, 1'b1};
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    // reset values, unmapped place and masked byte lane
    rdc(srx_pkg::ADR_ACC, 32'h0000_0000);
    rdc(srx_pkg::ADR_STAT, 32'h0000_0018);
    wr(12'h100, 32'h0000_00ff);
    rdc(12'h100, 32'h0000_0000);
    wb_op(1'b1, srx_pkg::ADR_ACC, 4'he, 32'h0000_0077);
    rdc(srx_pkg::ADR_ACC, 32'h0000_0000);
    // the empty operation changes nothing
    wr(srx_pkg::ADR_CMD, cw(srx_pkg::OP_NONE, 1'b1, 7'h00, 8'h55));
    rdc(srx_pkg::ADR_ACC, 32'h0000_0000);
    rdc(srx_pkg::ADR_STAT, 32'h0000_0018);
    rdc(srx_pkg::ADR_PC, 32'h0000_0000);
    // return pops twice, with reads between, and leaves flags alone
    wr(srx_pkg::ADR_PUSH, 32'h0000_0123);
    wr(srx_pkg::ADR_PUSH, 32'h0000_0456);
    rdc(srx_pkg::ADR_PUSH, 32'h0000_0002);
    wr(srx_pkg::ADR_STAT, 32'h0000_0007);
    wr(srx_pkg::ADR_CMD, cw(srx_pkg::OP_RET, 1'b0, 7'h00, 8'h00));
    check({19'h0, pc_o}, 32'h0000_0456);
    rdc(srx_pkg::ADR_STAT, 32'h0000_001f);
    rdc(srx_pkg::ADR_CMD, 32'h0000_0000);
    wr(srx_pkg::ADR_CMD, cw(srx_pkg::OP_RET, 1'b0, 7'h00, 8'h00));
    rdc(srx_pkg::ADR_PC, 32'h0000_0123);
    rdc(srx_pkg::ADR_PUSH, 32'h0000_0000);
    // rotate right through carry, both destinations and edge addresses
    for (int i = 0; i < 4; i++) begin
      wr(fa(i[0] ? 7'h7f : 7'h00), {24'h0, rv[i]});
      wr(srx_pkg::ADR_ACC, 32'h0000_005a);
      wr(srx_pkg::ADR_STAT, {29'h0, 2'b01, rc[i]});
      wr(srx_pkg::ADR_CMD, cw(srx_pkg::OP_RRF, i[0],
                              i[0] ? 7'h7f : 7'h00, 8'h00));
      res = {rc[i], rv[i][7:1]};
      rdc(srx_pkg::ADR_ACC, {24'h0, i[0] ? 8'h5a : res});
      rdc(fa(i[0] ? 7'h7f : 7'h00), {24'h0, i[0] ? res : rv[i]});
      rdc(srx_pkg::ADR_STAT, {27'h0, 4'b1101, rv[i][0]});
    end
    // both subtract forms over borrow, half borrow and zero cases
    for (int i = 0; i < 6; i++) begin
      for (int m = 0; m < 3; m++) begin
        res = ka[i] - wa[i];
        ef = {res == 8'h00, ka[i][3:0] >= wa[i][3:0], ka[i] >= wa[i]};
        wr(fa(7'h15), {24'h0, ka[i]});
        wr(srx_pkg::ADR_ACC, {24'h0, wa[i]});
        wr(srx_pkg::ADR_CMD, cw(m == 0 ? srx_pkg::OP_LITERAL_MINUS_ACC_OP : srx_pkg::OP_REG_MINUS_ACC_OP,
                                m == 2, 7'h15, ka[i]));
        rdc(srx_pkg::ADR_ACC, {24'h0, m == 2 ? wa[i] : res});
        rdc(fa(7'h15), {24'h0, m == 2 ? res : ka[i]});
        wb_op(1'b0, srx_pkg::ADR_STAT, 4'hf, 32'h0000_0000);
        check(rd & 32'h0000_001f, {27'h0, 2'b11, ef});
      end
    end
    // halt clears the watchdog, sets the flags and stops execution
    wb_op(1'b0, srx_pkg::ADR_WDOG, 4'hf, 32'h0000_0000);
    check({31'h0, |rd[15:0]}, 32'h0000_0001);
    wr(srx_pkg::ADR_ACC, 32'h0000_0033);
    wr(srx_pkg::ADR_CMD, cw(srx_pkg::OP_HALT, 1'b0, 7'h00, 8'h00));
    check({31'h0, sleep_o}, 32'h0000_0001);
    rdc(srx_pkg::ADR_WDOG, 32'h0000_0000);
    wb_op(1'b0, srx_pkg::ADR_STAT, 4'hf, 32'h0000_0000);
    check(rd & 32'h0000_0018, 32'h0000_0010);
    wr(srx_pkg::ADR_CMD, cw(srx_pkg::OP_LITERAL_MINUS_ACC_OP, 1'b0, 7'h00, 8'h99));
    repeat (20) @(posedge clock_i);
    rdc(srx_pkg::ADR_ACC, 32'h0000_0033);
    rdc(srx_pkg::ADR_WDOG, 32'h0000_0000);
    rdc(srx_pkg::ADR_CMD, 32'h0000_0002);
    wr(srx_pkg::ADR_WAKE, 32'h0000_0001);
    check({31'h0, sleep_o}, 32'h0000_0000);
    summarize();
  end

endmodule // srx_exec_tb
